/* File: hw/sae_pkg.sv */
// package: constants, carriers and state codes of the audio extract output block
package sae_pkg;

  // ==========================================================================
  // register port map (byte offsets, 7-bit address)
  localparam int ADDR_W = 7;
  localparam logic [6:0] REG_CTRL = 7'h00;
  localparam logic [6:0] REG_PRES = 7'h01;
  localparam logic [6:0] REG_STAT = 7'h02;
  localparam logic [6:0] REG_ERR = 7'h04;
  localparam logic [6:0] REG_FIFO = 7'h06;
  localparam logic [6:0] REG_CLK = 7'h07;
  localparam int CSRAM_SEL_BIT = 6;
  localparam int CSRAM_ADDR_W = 6;

  // ==========================================================================
  // field layouts and reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PAIR_LSB = 1;
  localparam int CTRL_PAIR_MSB = 4;
  localparam int CTRL_MUTE_BIT = 5;
  localparam int STAT_ASYNC_BIT = 4;
  localparam int ERR_CNT_W = 4;
  localparam logic [3:0] ERR_CNT_MAX = 4'hF;
  localparam logic [3:0] ERR_CNT_ONE = 4'h1;
  localparam int FIFO_UNF_BIT = 0;
  localparam int FIFO_OVF_BIT = 1;
  localparam int FIFO_FULL_BIT = 2;
  localparam int FIFO_CLEAR_BIT = 0;

  // ==========================================================================
  // audio framing and timing
  localparam int SAMPLE_W = 24;
  localparam int CHAN_W = 8;
  localparam int SLOT_W = 32;
  localparam int BITCNT_W = 6;
  localparam logic [5:0] BITCNT_LEFT = 6'h00;
  localparam logic [5:0] BITCNT_RIGHT = 6'h20;
  localparam int WS_BIT = 5;
  localparam int AUD_CLK_HZ = 3072000;
  localparam int CORE_CLK_HZ = 100000000;
  localparam int MIN_OVERSAMPLE = 4;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [23:0] left;
    logic [23:0] right;
  } sae_pair_t;

  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [7:0] channel;
    logic [23:0] data;
  } sae_stream_t;

  typedef struct packed {
    logic de;
    logic ws;
    logic data;
  } sae_serial_t;

  typedef enum logic [2:0] {
    SST_IDLE = 3'b001,
    SST_LEFT = 3'b010,
    SST_RIGHT = 3'b100
  } sae_sst_t;

endpackage

/* File: hw/sae_outputs.sv */
// module: audio extract output stage, serial or stream, with direct control port
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

// Function
// - with SD video only video-synchronous audio is carried; asynchronous audio is muted
// - data enable is high whenever word select and serial data are valid
// - in synchronous operation data enable stays permanently high
// - word select frames the serial data and marks left or right sample
// - serial data carries the AES-format slot of the output stage
// - every stream signal moves with the audio clock
// - valid is high in every cycle that stream data is presented
// - start flag on first transfer of a frame, end flag on the last
// - each transfer holds a 24-bit sample and an 8-bit channel index
// - control port is sampled and updated on the control clock only
// - control word acts as the control register; status words mirror their registers
// - a pulse on an error-clear bit clears the matching error status bit
// - an error-clear pulse on bits 3:0 resets the whole 4-bit error counter
// - a buffer-clear pulse clears the underflow and overflow flags
// - channel status byte for a 6-bit address appears one control clock later
// - build-time choice between stream output and serial audio output
// - control bit 0 enables, bits 4:1 pick the pair, bit 5 mutes
module sae_outputs import sae_pkg::*; #(
  parameter bit STREAM_MODE = 1'b0,
  parameter int CLK_HZ = CORE_CLK_HZ
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // extractor side, core_clk domain
  input wire logic pair_valid,
  input wire sae_pair_t pair_in,
  input wire logic [7:0] presence_in,
  input wire logic [7:0] status_in,
  input wire logic [7:0] clock_status_in,
  input wire logic [3:0] err_flag_evt,
  input wire logic err_count_evt,
  input wire logic vid_is_sd,
  input wire logic cs_wr,
  input wire logic [CSRAM_ADDR_W-1:0] cs_waddr,
  input wire logic [7:0] cs_wdata,
  // audio link pins
  input wire logic aud_clk,
  input wire logic external_word_select_in,
  input wire logic stream_ready,
  output sae_serial_t serial_out,
  output sae_stream_t stream_out,
  output logic [7:0] control_word
);

  // ==========================================================================
  // elaboration checks
  initial begin
    if (CLK_HZ < MIN_OVERSAMPLE * AUD_CLK_HZ) begin
      $error("core clock too slow to sample the audio clock");
    end
  end

  // ==========================================================================
  // state
  typedef struct packed {
    logic [2:0] aclk_sync;
    logic [2:0] ews_sync;
    logic [1:0] rdy_sync;
    logic align_pend;
    logic [7:0] ctrl;
    logic [7:0] pres;
    logic [7:0] stat;
    logic [7:0] clk_stat;
    logic [3:0] err_flags;
    logic [3:0] err_cnt;
    logic unf;
    logic ovf;
    logic [7:0] rdata;
    logic pend;
    sae_pair_t pair;
    sae_pair_t frame;
    logic [5:0] bit_cnt;
    logic [31:0] shreg;
    sae_serial_t ser;
    sae_stream_t strm;
    sae_sst_t sst;
  } sae_state_t;

  sae_state_t st_q;
  sae_state_t st_d;
  logic [7:0] cs_mem [0:(1<<CSRAM_ADDR_W)-1];

  // builds one 32-bit subframe slot: sample, aux, validity, user, status, parity
  function automatic logic [31:0] sae_slot(input logic [23:0] s);
    logic [30:0] body;
    body = {s, 4'h0, 3'b000};
    return {body, ^body};
  endfunction

  // gated sample: mute forces digital silence rather than stopping the link
  function automatic logic [23:0] sae_gate(input logic [23:0] s, input logic m);
    return m ? 24'h000000 : s;
  endfunction

  // ==========================================================================
  // channel status memory, written by the extractor
  always_ff @(posedge core_clk) begin
    if (ce && cs_wr) begin
      cs_mem[cs_waddr] <= cs_wdata;
    end
  end

  // ==========================================================================
  // next-state logic
  logic aclk_rise;
  logic aclk_fall;
  logic ews_fall;
  logic enable;
  logic mute;
  logic [3:0] pair_sel;
  logic consume;
  logic [3:0] err_clr;

  always_comb begin
    st_d = st_q;
    consume = 1'b0;
    // edges are found only between second and third stage, never on the first
    aclk_rise = st_q.aclk_sync[1] & ~st_q.aclk_sync[2];
    aclk_fall = ~st_q.aclk_sync[1] & st_q.aclk_sync[2];
    ews_fall = ~st_q.ews_sync[1] & st_q.ews_sync[2];
    enable = st_q.ctrl[CTRL_EN_BIT];
    pair_sel = st_q.ctrl[CTRL_PAIR_MSB:CTRL_PAIR_LSB];
    // sd video cannot carry asynchronous audio from this clock, so silence it
    mute = st_q.ctrl[CTRL_MUTE_BIT] | (vid_is_sd & st_q.stat[STAT_ASYNC_BIT]);

    // pin synchronisers, audio clock sampled as a plain input
    st_d.aclk_sync = {st_q.aclk_sync[1:0], aud_clk};
    st_d.ews_sync = {st_q.ews_sync[1:0], external_word_select_in};
    st_d.rdy_sync = {st_q.rdy_sync[0], stream_ready};

    // mirrored status words, refreshed every control clock
    st_d.pres = presence_in;
    st_d.stat = status_in;
    st_d.clk_stat = clock_status_in;

    // register port: writes and one-cycle-late read data
    st_d.rdata = 8'h00;
    err_clr = 4'h0;
    if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        st_d.ctrl = reg_wdata;
      end
      if (reg_addr == REG_ERR) begin
        err_clr = reg_wdata[7:4];
        if (|reg_wdata[3:0]) begin
          st_d.err_cnt = 4'h0;
        end
      end
      if (reg_addr == REG_FIFO && reg_wdata[FIFO_CLEAR_BIT]) begin
        st_d.unf = 1'b0;
        st_d.ovf = 1'b0;
      end
    end
    if (reg_rd) begin
      if (reg_addr[CSRAM_SEL_BIT]) begin
        st_d.rdata = cs_mem[reg_addr[CSRAM_ADDR_W-1:0]];
      end else begin
        case (reg_addr)
          REG_CTRL: st_d.rdata = st_q.ctrl;
          REG_PRES: st_d.rdata = st_q.pres;
          REG_STAT: st_d.rdata = st_q.stat;
          REG_ERR: st_d.rdata = {st_q.err_flags, st_q.err_cnt};
          REG_FIFO: st_d.rdata = {5'h00, st_q.pend, st_q.ovf, st_q.unf};
          REG_CLK: st_d.rdata = st_q.clk_stat;
          default: st_d.rdata = 8'h00;
        endcase
      end
    end

    // sticky error flags: a new event beats a clear in the same cycle
    st_d.err_flags = (st_q.err_flags & ~err_clr) | err_flag_evt;
    // saturating counter; an event beside a clear counts from zero
    if (err_count_evt) begin
      if (st_d.err_cnt != ERR_CNT_MAX) begin
        st_d.err_cnt = st_d.err_cnt + ERR_CNT_ONE;
      end
    end

    // ------------------------------------------------------------------------
    // serial link: bits change on the audio clock falling edge
    if (!STREAM_MODE) begin
      st_d.ser.de = 1'b1;
      if (ews_fall) begin
        st_d.align_pend = 1'b1;
      end
      if (aclk_fall) begin
        st_d.bit_cnt = st_q.bit_cnt + 6'h01;
        if (st_q.align_pend || st_d.align_pend) begin
          st_d.bit_cnt = BITCNT_LEFT;
          st_d.align_pend = 1'b0;
        end
        st_d.shreg = {st_q.shreg[SLOT_W-2:0], 1'b0};
        if (st_d.bit_cnt == BITCNT_LEFT) begin
          if (st_q.pend && enable) begin
            consume = 1'b1;
            st_d.frame = st_q.pair;
          end else begin
            st_d.frame = '0;
            if (enable) begin
              st_d.unf = 1'b1;
            end
          end
          st_d.shreg = sae_slot(sae_gate(st_d.frame.left, mute));
        end else if (st_d.bit_cnt == BITCNT_RIGHT) begin
          st_d.shreg = sae_slot(sae_gate(st_q.frame.right, mute));
        end
        st_d.ser.ws = st_d.bit_cnt[WS_BIT];
        st_d.ser.data = enable & st_d.shreg[SLOT_W-1];
      end
    end

    // ------------------------------------------------------------------------
    // stream link: moves only at audio clock rising edges
    if (STREAM_MODE && aclk_rise) begin
      case (st_q.sst)
        SST_IDLE: begin
          if (enable && st_q.pend) begin
            consume = 1'b1;
            st_d.frame = st_q.pair;
            st_d.strm.valid = 1'b1;
            st_d.strm.sop = 1'b1;
            st_d.strm.eop = 1'b0;
            st_d.strm.channel = {3'b000, pair_sel, 1'b0};
            st_d.strm.data = sae_gate(st_q.pair.left, mute);
            st_d.sst = SST_LEFT;
          end
        end
        SST_LEFT: begin
          if (st_q.rdy_sync[1]) begin
            st_d.strm.sop = 1'b0;
            st_d.strm.eop = 1'b1;
            st_d.strm.channel = {3'b000, pair_sel, 1'b1};
            st_d.strm.data = sae_gate(st_q.frame.right, mute);
            st_d.sst = SST_RIGHT;
          end
        end
        SST_RIGHT: begin
          if (st_q.rdy_sync[1]) begin
            if (enable && st_q.pend) begin
              consume = 1'b1;
              st_d.frame = st_q.pair;
              st_d.strm.sop = 1'b1;
              st_d.strm.eop = 1'b0;
              st_d.strm.channel = {3'b000, pair_sel, 1'b0};
              st_d.strm.data = sae_gate(st_q.pair.left, mute);
              st_d.sst = SST_LEFT;
            end else begin
              st_d.strm = '0;
              st_d.sst = SST_IDLE;
            end
          end
        end
        default: begin
          st_d.strm = '0;
          st_d.sst = SST_IDLE;
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // one-pair holding stage; a pair arriving while full overwrites the old one
    if (consume) begin
      st_d.pend = 1'b0;
    end
    if (pair_valid) begin
      if (st_q.pend && !consume) begin
        st_d.ovf = 1'b1;
      end
      st_d.pend = 1'b1;
      st_d.pair = pair_in;
    end
  end

  // ==========================================================================
  // state register, frozen while ce is low
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_q <= '{ctrl: CTRL_RESET, sst: SST_IDLE, default: '0};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // outputs straight from the state register
  assign reg_rdata = st_q.rdata;
  assign serial_out = st_q.ser;
  assign stream_out = st_q.strm;
  assign control_word = st_q.ctrl;

endmodule

/* File: dv/sae_outputs_sva.sv */
// checker: port assertions for the audio extract output stage
`timescale 1ns/1ps
module sae_outputs_sva import sae_pkg::*; #(
  parameter bit STREAM_MODE = 1'b0
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] presence_in,
  input wire logic [3:0] err_flag_evt,
  input wire logic err_count_evt,
  input wire logic pair_valid,
  input wire logic cs_wr,
  input wire logic [CSRAM_ADDR_W-1:0] cs_waddr,
  input wire logic [7:0] cs_wdata,
  input wire sae_serial_t serial_out,
  input wire sae_stream_t stream_out,
  input wire logic [7:0] control_word
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ==========================================================================
  // sequences: a write, or a read, immediately followed by a read of the same word
  sequence s_err_clr_rd;
    (reg_wr && reg_addr == REG_ERR && !err_count_evt && err_flag_evt == 4'h0)
      ##1 (reg_rd && reg_addr == REG_ERR && !err_count_evt && err_flag_evt == 4'h0);
  endsequence
  sequence s_err_rd2;
    (reg_rd && reg_addr == REG_ERR) ##1 (reg_rd && reg_addr == REG_ERR);
  endsequence
  // ==========================================================================
  // assertions
  a_de_steady: assert property (!STREAM_MODE && ce && !$past(reset) |-> serial_out.de)
    else $error("data enable dropped");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_ctrl_copy: assert property (ce && reg_wr && reg_addr == REG_CTRL |=>
    control_word[5:0] == $past(reg_wdata[5:0])) else $error("control word not written");
  a_pres_mirror: assert property (reg_rd && reg_addr == REG_PRES && $stable(presence_in) |=>
    reg_rdata == $past(presence_in)) else $error("presence word not mirrored");
  a_err_flag_clr: assert property (s_err_clr_rd |=>
    (reg_rdata[7:4] & $past(reg_wdata[7:4], 2)) == 4'h0) else $error("error flag not cleared");
  a_err_cnt_clr: assert property (s_err_clr_rd ##0 $past(reg_wdata[3:0]) != 4'h0 |=>
    reg_rdata[3:0] == 4'h0) else $error("error counter not cleared");
  a_err_sticky: assert property (s_err_rd2 |=>
    ($past(reg_rdata[7:4]) & ~reg_rdata[7:4]) == 4'h0) else $error("error flag lost");
  a_buf_clr: assert property ((reg_wr && reg_addr == REG_FIFO && reg_wdata[FIFO_CLEAR_BIT] &&
    !control_word[CTRL_EN_BIT] && !pair_valid) ##1 (reg_rd && reg_addr == REG_FIFO && !pair_valid)
    |=> !reg_rdata[FIFO_UNF_BIT] && !reg_rdata[FIFO_OVF_BIT]) else $error("buffer flags kept");
  a_cs_read: assert property (cs_wr ##1 (reg_rd && !cs_wr && reg_addr == {1'h1, $past(cs_waddr)})
    |=> reg_rdata == $past(cs_wdata, 2)) else $error("channel status byte wrong");
  a_stream_quiet: assert property (!STREAM_MODE |-> !stream_out.valid)
    else $error("stream active in serial build");
endmodule

bind sae_outputs sae_outputs_sva #(.STREAM_MODE(STREAM_MODE)) i_sva (.core_clk, .reset, .ce,
  .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .presence_in, .err_flag_evt, .err_count_evt, .pair_valid, .cs_wr,
  .cs_waddr, .cs_wdata, .serial_out, .stream_out, .control_word);

/* File: dv/sae_audio_sink.sv */
// partner: serial audio receiver that clocks the link and captures left slots
`timescale 1ns/1ps
module sae_audio_sink import sae_pkg::*; (
  input wire sae_serial_t serial_in,
  output logic aud_clk,
  output logic ews,
  output logic ready,
  output logic [31:0] left_word,
  output int unsigned frames
);
  logic [31:0] shift_q;
  logic ws_q;
  // ==========================================================================
  // bit clock, 160 ns, offset so its edges never meet the core clock edges
  initial begin
    aud_clk = 1'h0;
    #3;
    forever #80 aud_clk = ~aud_clk;
  end
  // single extractor: alignment input held low; the sink never stalls
  assign ews = 1'h0;
  assign ready = 1'h1;
  // sample on the rising bit clock, half a period after its falling edge and 58 ns after the line moved
  always @(posedge aud_clk) begin
    if (!serial_in.ws) shift_q <= {shift_q[30:0], serial_in.data};
    if (serial_in.ws && !ws_q) begin
      left_word <= shift_q;
      frames <= frames + 1;
    end
    ws_q <= serial_in.ws;
  end
endmodule

/* File: dv/sae_outputs_tb.sv */
// testbench: register port, flags, channel status and serial link
`timescale 1ns/1ps
`define CHECK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL %0s expected %h seen %h", n, e, g); end end
module sae_outputs_tb import sae_pkg::*;;
  logic core_clk, reset, ce, reg_wr, reg_rd, pair_valid, vid_is_sd, cs_wr, err_count_evt;
  logic aud_clk, ews, ready;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, presence_in, status_in, clock_status_in, cs_wdata;
  logic [7:0] control_word;
  logic [3:0] err_flag_evt;
  logic [5:0] cs_waddr;
  logic [31:0] left_word, exp_slot;
  sae_pair_t pair_in;
  sae_serial_t serial_out;
  sae_stream_t stream_out;
  sae_stream_t stream_s;
  logic [7:0] rdata_s;
  int unsigned frames;
  int mismatches, num_checks;
  sae_outputs #(.STREAM_MODE(1'h0), .CLK_HZ(CORE_CLK_HZ)) i_dut (.core_clk, .reset, .ce,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pair_valid, .pair_in, .presence_in,
    .status_in, .clock_status_in, .err_flag_evt, .err_count_evt, .vid_is_sd, .cs_wr,
    .cs_waddr, .cs_wdata, .aud_clk, .external_word_select_in(ews), .stream_ready(ready),
    .serial_out, .stream_out, .control_word);
  // second build with the packet stream, sharing every input with the serial one
  sae_outputs #(.STREAM_MODE(1'h1), .CLK_HZ(CORE_CLK_HZ)) i_dut_strm (.core_clk, .reset, .ce,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rdata_s), .pair_valid, .pair_in,
    .presence_in, .status_in, .clock_status_in, .err_flag_evt, .err_count_evt, .vid_is_sd,
    .cs_wr, .cs_waddr, .cs_wdata, .aud_clk, .external_word_select_in(ews),
    .stream_ready(ready), .serial_out(), .stream_out(stream_s), .control_word());
  sae_audio_sink i_sink (.serial_in(serial_out), .aud_clk, .ews, .ready, .left_word, .frames);
  // ==========================================================================
  // clock, 10 ns
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  // ==========================================================================
  // tasks; each is entered 1 ns after an edge and leaves 1 ns after one
  task automatic print_verdict();
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
    #1;
  endtask
  task automatic chk_rd(input string n, input logic [6:0] a, input logic [7:0] m, e);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1;
    `CHECK(n, e, reg_rdata & m)
  endtask
  task automatic pulse_pair();
    pair_valid <= 1'h1;
    @(posedge core_clk);
    pair_valid <= 1'h0;
    #1;
  endtask
  // bounded wait for the sink to capture another left slot
  task automatic wait_frame();
    int unsigned f;
    f = frames;
    for (int n = 0; n < 2000 && frames == f; n++) @(posedge core_clk);
    if (frames == f) begin
      mismatches++;
      print_verdict();
    end else begin
      #1;
    end
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    {reset, ce} = 2'h3;
    {vid_is_sd, reg_wr, reg_rd, pair_valid, cs_wr, err_count_evt} = 6'h00;
    {reg_addr, reg_wdata, cs_waddr, cs_wdata, err_flag_evt} = 33'h0;
    pair_in = {24'hABCDEF, 24'h123456};
    {presence_in, status_in, clock_status_in} = 24'hA50C5A;
    {mismatches, num_checks} = 64'h0;
    exp_slot = {24'hABCDEF, 7'h00, ^24'hABCDEF};
    repeat (5) @(posedge core_clk);
    reset <= 1'h0;
    @(posedge core_clk);
    #1;
    chk_rd("ctrl reset", REG_CTRL, 8'hFF, CTRL_RESET);
    // channel pair codes 0 to 7 land in the control word
    for (int i = 0; i < 8; i++) begin
      wr(REG_CTRL, {4'h0, i[2:0], 1'h0});
      `CHECK("pair", {4'h0, i[2:0], 1'h0}, control_word)
    end
    chk_rd("ctrl", REG_CTRL, 8'h3F, 8'h0E);
    wr(REG_PRES, 8'h00);
    chk_rd("presence", REG_PRES, 8'hFF, 8'hA5);
    chk_rd("status", REG_STAT, 8'hFF, 8'h0C);
    chk_rd("clock", REG_CLK, 8'hFF, 8'h5A);
    chk_rd("unmapped", 7'h03, 8'hFF, 8'h00);
    // error flags and counter: set, read twice, clear part
    err_flag_evt <= 4'hA;
    repeat (3) begin
      err_count_evt <= 1'h1;
      @(posedge core_clk);
      {err_flag_evt, err_count_evt} <= 5'h00;
      @(posedge core_clk);
      #1;
    end
    chk_rd("error", REG_ERR, 8'hFF, 8'hA3);
    chk_rd("error again", REG_ERR, 8'hFF, 8'hA3);
    wr(REG_ERR, 8'h81);
    chk_rd("error cleared", REG_ERR, 8'hFF, 8'h20);
    // buffer: two pairs with extraction off overflow the holding stage
    pulse_pair();
    pulse_pair();
    chk_rd("buffer", REG_FIFO, 8'h06, 8'h06);
    wr(REG_FIFO, 8'h01);
    chk_rd("buffer cleared", REG_FIFO, 8'h03, 8'h00);
    // channel status byte, read right after it was written
    {cs_wr, cs_waddr, cs_wdata} <= {1'h1, 6'h25, 8'h3C};
    @(posedge core_clk);
    cs_wr <= 1'h0;
    #1;
    chk_rd("cs byte", 7'h65, 8'hFF, 8'h3C);
    // enabling sends the held pair as the next left slot
    wr(REG_CTRL, 8'h01);
    // stream build: the held pair leaves as one two-transfer frame
    for (int n = 0; n < 100 && stream_s.valid !== 1'h1; n++) @(posedge core_clk);
    #1;
    `CHECK("stream left", {1'h1, 1'h1, 1'h0, 8'h00, 24'hABCDEF}, stream_s)
    for (int n = 0; n < 100 && stream_s.eop !== 1'h1; n++) @(posedge core_clk);
    #1;
    `CHECK("stream right", {1'h1, 1'h0, 1'h1, 8'h01, 24'h123456}, stream_s)
    for (int k = 0; k < 4 && left_word !== exp_slot; k++) wait_frame();
    `CHECK("left slot", exp_slot, left_word)
    `CHECK("data enable", 1'h1, serial_out.de)
    // muted: fresh pairs each frame must still come out as silence
    wr(REG_CTRL, 8'h21);
    for (int k = 0; k < 3; k++) begin
      wait_frame();
      pulse_pair();
    end
    wait_frame();
    `CHECK("muted slot", 32'h00000000, left_word)
    print_verdict();
  end
endmodule
